// [asr_top.sv]
/*
  Moded asynchronous serial receiver and simple transmitter with APB registers.
  Assumes pin inputs synchronous to pclk and a remote serial device on the pins.
*/
// Implementation choices: the placing of the registers and the APB register port.
// Overview of operation
// - Baud field is the low 13 mode bits.
// - Bit period equals baud field plus 20 us.
// - Mode bit 13 selects 7E1, else 8N1.
// - Mode bit 14 inverts data and flow pins.
// - Mode bit 15 never affects reception.
// - Data pin input, flow pin output when used.
// - Flow pin enabled before each received character.
// - Bad even parity aborts with parity exit.
// - No character within timeout ms aborts.
// - Qualifier mismatch restarts matching at first byte.
// - Qualifier string held in a byte array.
// - Skip item discards next n characters.
// - String item stores until count or terminator.
// - Plain item stores raw character code.
// - Numeric items parse digits, drop non-digits.
// - Digit count fixes digits consumed, else unlimited.
// - Microsecond timebase scales with oscillator setting.
// - Transmitter sends 8N1 with pin as output.
// - Mode code picks baud, polarity, drive style.
// - Raw byte or its decimal digits sent.
// - Optional pacing gap between characters in us.
// - Transmit pin becomes output at first send.
`timescale 1ns/1ps
module asr_top #(
  parameter int unsigned CYC_PER_US = asr_pkg::CLK_MHZ,
  parameter int STR_N = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [asr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serial_data_pin_i,
  output logic flow_control_pin_o,
  output logic flow_control_pin_oe_n,
  output logic tx_pin_o,
  output logic tx_pin_oe_n
);
  import asr_pkg::*;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Returns {valid, value} for an ASCII digit of the item's radix.
  function automatic logic [4:0] asr_digit(input logic [7:0] c, input logic [2:0] k);
    logic [4:0] r;
    r = 5'h00;
    if (k == IT_BIN && (c == ASC_0 || c == ASC_1)) r = {1'b1, 4'(c - ASC_0)};
    if (k != IT_BIN && c >= ASC_0 && c <= ASC_9) r = {1'b1, 4'(c - ASC_0)};
    if (k == IT_HEX && c >= ASC_UA && c <= ASC_UF) r = {1'b1, 4'(c - HEX_U_OFS)};
    if (k == IT_HEX && c >= ASC_LA && c <= ASC_LF) r = {1'b1, 4'(c - HEX_L_OFS)};
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    RB_IDLE = 4'b0001, RB_START = 4'b0010, RB_DATA = 4'b0100, RB_STOP = 4'b1000
  } asr_rxst_e;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001, TX_BITS = 3'b010, TX_PACE = 3'b100
  } asr_txst_e;

  logic [15:0] rx_mode_reg;
  asr_rxctrl_s rx_ctrl_reg;
  logic [15:0] rx_tmo_reg;
  logic [7:0] qual_reg [4];
  logic [7:0] str_reg [STR_N];
  asr_txctrl_s tx_ctrl_reg;
  logic [7:0] osc_reg;
  logic [31:0] rdata_next;
  logic slverr_next;
  logic [15:0] presc_reg;
  logic us_tick_reg;
  asr_rxst_e rxs_reg;
  logic [13:0] rx_us_reg;
  logic [2:0] rx_bit_reg;
  logic [7:0] rx_sh_reg;
  logic char_ev_reg;
  logic busy_reg, done_reg, perr_reg, tmo_reg;
  logic [2:0] qpos_reg;
  logic [3:0] left_reg;
  logic got_reg;
  logic [15:0] val_reg;
  logic [3:0] sidx_reg;
  logic [9:0] ms_us_reg;
  logic [15:0] ms_reg;
  asr_txst_e txs_reg;
  logic [9:0] tx_sh_reg;
  logic [3:0] tx_bit_reg;
  logic [15:0] tx_us_reg;
  logic [7:0] tx_val_reg;
  logic [1:0] tx_rem_reg;
  logic tx_dir_reg;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state lets read data and the error answer come from flops.
  logic acc, wr, rx_start, tx_go;
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign rx_start = wr && paddr == A_RXCTRL && pwdata[0] && !busy_reg;
  assign tx_go = wr && paddr == A_TXDATA && txs_reg == TX_IDLE && tx_rem_reg == 2'h0;

  // Read mux and unmapped-address detection.
  always_comb begin
    rdata_next = 32'h0000_0000;
    slverr_next = 1'b0;
    case (paddr)
      A_RXMODE: rdata_next = {16'h0000, rx_mode_reg};
      A_RXCTRL: rdata_next = 32'(rx_ctrl_reg);
      A_RXTMO: rdata_next = {16'h0000, rx_tmo_reg};
      A_QUAL: rdata_next = {qual_reg[3], qual_reg[2], qual_reg[1], qual_reg[0]};
      A_RXSTAT: rdata_next = {16'h0000, rx_sh_reg, 4'h0, tmo_reg, perr_reg, done_reg, busy_reg};
      A_RXVAL: rdata_next = {16'h0000, val_reg};
      A_TXCTRL: rdata_next = 32'(tx_ctrl_reg);
      A_TXDATA: rdata_next = {31'h0000_0000, txs_reg != TX_IDLE || tx_rem_reg != 2'h0};
      A_OSC: rdata_next = {24'h00_0000, osc_reg};
      default: begin
        if (paddr[7:4] == A_STR_HI && 32'(paddr[3:2]) * 4 < STR_N) begin
          for (int b = 0; b < 4; b++) begin
            rdata_next[b*8 +: 8] = str_reg[4 * paddr[3:2] + 2'(b)];
          end
        end else begin
          slverr_next = 1'b1;
        end
      end
    endcase
  end

  // Bus answer flops.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & !pready;
      if (psel & penable & !pready) begin
        prdata <= pwrite ? 32'h0000_0000 : rdata_next;
        pslverr <= slverr_next;
      end
    end
  end

  // Software-written configuration.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_mode_reg <= RXMODE_RST;
      rx_ctrl_reg <= '0;
      rx_tmo_reg <= 16'h0000;
      tx_ctrl_reg <= '0;
      osc_reg <= OSC_DEF_MHZ;
      for (int i = 0; i < 4; i++) qual_reg[i] <= 8'h00;
    end else if (wr) begin
      case (paddr)
        A_RXMODE: rx_mode_reg <= pwdata[15:0];
        A_RXCTRL: if (!busy_reg) rx_ctrl_reg <= {pwdata[21:1], 1'b0};
        A_RXTMO: rx_tmo_reg <= pwdata[15:0];
        A_QUAL: for (int i = 0; i < 4; i++) qual_reg[i] <= pwdata[i*8 +: 8];
        A_TXCTRL: tx_ctrl_reg <= pwdata[20:0];
        A_OSC: osc_reg <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Microsecond timebase
  // ----------------------------------------------------------------
  // The tick is free running, so every interval carries up to 1 us of phase error.
  logic [15:0] us_div;
  assign us_div = 16'((CYC_PER_US * osc_reg) / OSC_DEF_MHZ);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_reg <= 16'h0000;
      us_tick_reg <= 1'b0;
    end else begin
      us_tick_reg <= presc_reg + 16'h0001 >= us_div;
      presc_reg <= (presc_reg + 16'h0001 >= us_div) ? 16'h0000 : presc_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Receiver bit engine
  // ----------------------------------------------------------------
  logic inv, par_mode, line;
  logic [13:0] bit_us;
  assign inv = rx_mode_reg[MB_INV];
  assign par_mode = rx_mode_reg[MB_PARITY];
  assign line = serial_data_pin_i ^ inv;
  assign bit_us = {1'b0, rx_mode_reg[BAUD_W-1:0]} + BAUD_BIAS_US;

  // Start detect, mid-bit check, eight samples (7E1 also has eight), stop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxs_reg <= RB_IDLE;
      rx_us_reg <= 14'h0000;
      rx_bit_reg <= 3'h0;
      rx_sh_reg <= 8'h00;
      char_ev_reg <= 1'b0;
    end else begin
      char_ev_reg <= 1'b0;
      if (!busy_reg) begin
        rxs_reg <= RB_IDLE;
      end else begin
        case (rxs_reg)
          RB_IDLE: begin
            rx_us_reg <= 14'h0000;
            if (!line) rxs_reg <= RB_START;
          end
          RB_START: if (us_tick_reg) begin
            rx_us_reg <= rx_us_reg + 14'h0001;
            if (rx_us_reg + 14'h0001 >= bit_us >> 1) begin
              rx_us_reg <= 14'h0000;
              rx_bit_reg <= 3'h0;
              rxs_reg <= line ? RB_IDLE : RB_DATA;
            end
          end
          RB_DATA, RB_STOP: if (us_tick_reg) begin
            rx_us_reg <= rx_us_reg + 14'h0001;
            if (rx_us_reg + 14'h0001 >= bit_us) begin
              rx_us_reg <= 14'h0000;
              if (rxs_reg == RB_STOP) begin
                char_ev_reg <= 1'b1;
                rxs_reg <= RB_IDLE;
              end else begin
                rx_sh_reg <= {line, rx_sh_reg[7:1]};
                rx_bit_reg <= rx_bit_reg + 3'h1;
                if (rx_bit_reg == RX_LAST_BIT) rxs_reg <= RB_STOP;
              end
            end
          end
          default: rxs_reg <= RB_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Receiver item engine
  // ----------------------------------------------------------------
  logic [7:0] c;
  logic par_bad, tmo_hit;
  logic [4:0] dg;
  logic [15:0] scaled;
  assign c = par_mode ? {1'b0, rx_sh_reg[6:0]} : rx_sh_reg;
  assign par_bad = par_mode & ^rx_sh_reg;
  assign tmo_hit = busy_reg && rx_tmo_reg != 16'h0000 && ms_reg >= rx_tmo_reg;
  assign dg = asr_digit(c, rx_ctrl_reg.kind);
  assign scaled = rx_ctrl_reg.kind == IT_BIN ? val_reg << 1 :
                  rx_ctrl_reg.kind == IT_HEX ? val_reg << 4 :
                  (val_reg << 3) + (val_reg << 1);

  // Millisecond timeout counter, restarted by every received character.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_us_reg <= 10'h000;
      ms_reg <= 16'h0000;
    end else if (!busy_reg || char_ev_reg) begin
      ms_us_reg <= 10'h000;
      ms_reg <= 16'h0000;
    end else if (us_tick_reg) begin
      ms_us_reg <= (32'(ms_us_reg) == US_PER_MS - 1) ? 10'h000 : ms_us_reg + 10'h001;
      if (32'(ms_us_reg) == US_PER_MS - 1) ms_reg <= ms_reg + 16'h0001;
    end
  end

  // Qualifier matching, then one data item per operation.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      perr_reg <= 1'b0;
      tmo_reg <= 1'b0;
      qpos_reg <= 3'h0;
      left_reg <= 4'h0;
      got_reg <= 1'b0;
      val_reg <= 16'h0000;
      sidx_reg <= 4'h0;
      for (int i = 0; i < STR_N; i++) str_reg[i] <= 8'h00;
    end else if (rx_start) begin
      busy_reg <= 1'b1;
      {done_reg, perr_reg, tmo_reg, got_reg} <= 4'h0;
      qpos_reg <= 3'h0;
      left_reg <= pwdata[7:4];
      val_reg <= 16'h0000;
      sidx_reg <= 4'h0;
    end else if (busy_reg && char_ev_reg) begin
      if (rx_ctrl_reg.perr_en && par_bad) begin
        busy_reg <= 1'b0;
        perr_reg <= 1'b1;
      end else if (qpos_reg < rx_ctrl_reg.qlen) begin
        qpos_reg <= (c == qual_reg[qpos_reg[1:0]]) ? qpos_reg + 3'h1 : 3'h0;
      end else begin
        case (rx_ctrl_reg.kind)
          IT_RAW: begin
            val_reg <= {8'h00, c};
            {busy_reg, done_reg} <= 2'b01;
          end
          IT_SKIP: begin
            left_reg <= left_reg - 4'h1;
            if (left_reg == 4'h1) {busy_reg, done_reg} <= 2'b01;
          end
          IT_STR: begin
            if (rx_ctrl_reg.term_en && c == rx_ctrl_reg.term) begin
              {busy_reg, done_reg} <= 2'b01;
            end else begin
              str_reg[sidx_reg] <= c;
              sidx_reg <= sidx_reg + 4'h1;
              left_reg <= left_reg - 4'h1;
              if (left_reg == 4'h1) {busy_reg, done_reg} <= 2'b01;
            end
          end
          default: begin
            if (dg[4]) begin
              val_reg <= scaled + {12'h000, dg[3:0]};
              got_reg <= 1'b1;
              left_reg <= left_reg - 4'h1;
              if (rx_ctrl_reg.cnt != 4'h0 && left_reg == 4'h1) begin
                {busy_reg, done_reg} <= 2'b01;
              end
            end else if (got_reg) begin
              {busy_reg, done_reg} <= 2'b01;
            end
          end
        endcase
      end
    end else if (tmo_hit) begin
      busy_reg <= 1'b0;
      tmo_reg <= 1'b1;
    end
  end

  // Flow pin shows the enabled level only while waiting for a start bit.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flow_control_pin_o <= 1'b0;
      flow_control_pin_oe_n <= 1'b1;
    end else begin
      flow_control_pin_oe_n <= !(busy_reg && rx_ctrl_reg.flow_en);
      flow_control_pin_o <= (busy_reg && rxs_reg == RB_IDLE) ^ inv;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  logic [11:0] tx_bit_us;
  logic tx_inv, tx_open, tx_lvl;
  logic [7:0] tx_ch;
  assign tx_inv = tx_ctrl_reg.mode[2];
  assign tx_open = tx_ctrl_reg.mode[3];
  always_comb begin
    case (tx_ctrl_reg.mode[1:0])
      2'h0: tx_bit_us = TX_US_2400;
      2'h1: tx_bit_us = TX_US_1200;
      2'h2: tx_bit_us = TX_US_9600;
      default: tx_bit_us = TX_US_300;
    endcase
    // Decimal digits go out most significant first, without leading zeros.
    case (tx_rem_reg)
      2'h3: tx_ch = ASC_0 + tx_val_reg / 8'h64;
      2'h2: tx_ch = ASC_0 + (tx_val_reg / 8'h0A) % 8'h0A;
      default: tx_ch = tx_ctrl_reg.dec_fmt ? ASC_0 + tx_val_reg % 8'h0A : tx_val_reg;
    endcase
  end
  assign tx_lvl = (txs_reg == TX_BITS ? tx_sh_reg[0] : 1'b1) ^ tx_inv;

  // Frame sequencer: pending characters, bit shifting and pacing gap.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txs_reg <= TX_IDLE;
      tx_sh_reg <= 10'h3FF;
      tx_bit_reg <= 4'h0;
      tx_us_reg <= 16'h0000;
      tx_val_reg <= 8'h00;
      tx_rem_reg <= 2'h0;
      tx_dir_reg <= 1'b0;
    end else begin
      case (txs_reg)
        TX_IDLE: begin
          if (tx_go) begin
            tx_val_reg <= pwdata[7:0];
            tx_rem_reg <= !tx_ctrl_reg.dec_fmt ? 2'h1 : pwdata[7:0] >= 8'h64 ? 2'h3 :
                          pwdata[7:0] >= 8'h0A ? 2'h2 : 2'h1;
          end else if (tx_rem_reg != 2'h0) begin
            tx_sh_reg <= {1'b1, tx_ch, 1'b0};
            tx_bit_reg <= 4'h0;
            tx_us_reg <= 16'h0000;
            tx_dir_reg <= 1'b1;
            txs_reg <= TX_BITS;
          end
        end
        TX_BITS: if (us_tick_reg) begin
          tx_us_reg <= tx_us_reg + 16'h0001;
          if (tx_us_reg + 16'h0001 >= {4'h0, tx_bit_us}) begin
            tx_us_reg <= 16'h0000;
            tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
            tx_bit_reg <= tx_bit_reg + 4'h1;
            if (tx_bit_reg == TX_LAST_BIT) begin
              tx_rem_reg <= tx_rem_reg - 2'h1;
              txs_reg <= tx_ctrl_reg.pace_us != 16'h0000 ? TX_PACE : TX_IDLE;
            end
          end
        end
        TX_PACE: if (us_tick_reg) begin
          tx_us_reg <= tx_us_reg + 16'h0001;
          if (tx_us_reg + 16'h0001 >= tx_ctrl_reg.pace_us) txs_reg <= TX_IDLE;
        end
        default: txs_reg <= TX_IDLE;
      endcase
    end
  end

  // Pin drive: open modes release the pin for the level equal to idle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pin_o <= 1'b0;
      tx_pin_oe_n <= 1'b1;
    end else begin
      tx_pin_o <= tx_lvl;
      tx_pin_oe_n <= !tx_dir_reg || (tx_open && tx_lvl != tx_inv);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_rx_bit_period: assert property (rxs_reg == RB_DATA |-> rx_us_reg < bit_us)
    else $error("receive bit counter exceeded bit time");
  a_flow_enabled: assert property (busy_reg && rx_ctrl_reg.flow_en && rxs_reg == RB_IDLE
    |=> !flow_control_pin_oe_n && flow_control_pin_o == !inv)
    else $error("flow pin not at enabled level");
  a_parity_exit: assert property (busy_reg && char_ev_reg && rx_ctrl_reg.perr_en && par_bad
    |=> perr_reg && !busy_reg && !done_reg)
    else $error("bad parity did not take parity exit");
  a_timeout_exit: assert property (tmo_hit && !char_ev_reg && !rx_start
    |=> tmo_reg && !busy_reg)
    else $error("timeout did not abort");
  a_qual_restart: assert property (busy_reg && char_ev_reg && !par_bad
    && qpos_reg < rx_ctrl_reg.qlen && c != qual_reg[qpos_reg[1:0]] |=> qpos_reg == 3'h0)
    else $error("qualifier mismatch did not restart");
  a_raw_store: assert property (busy_reg && char_ev_reg && !par_bad
    && qpos_reg == rx_ctrl_reg.qlen && rx_ctrl_reg.kind == IT_RAW
    |=> val_reg == {8'h00, $past(c)} && done_reg)
    else $error("raw character not stored");
  a_skip_hold: assert property (busy_reg && char_ev_reg && !par_bad
    && qpos_reg == rx_ctrl_reg.qlen && rx_ctrl_reg.kind == IT_SKIP && left_reg != 4'h1
    |=> busy_reg && !done_reg)
    else $error("skip ended early");
  a_tx_frame: assert property (txs_reg == TX_IDLE && !tx_go && tx_rem_reg != 2'h0
    |=> txs_reg == TX_BITS && tx_sh_reg[0] == 1'b0 && tx_sh_reg[9] == 1'b1)
    else $error("transmit frame not 8N1");
  a_tx_driven: assert property (txs_reg == TX_BITS && !tx_open ##1 txs_reg == TX_BITS
    |-> !tx_pin_oe_n)
    else $error("driven transmit pin not output");
endmodule

// [asr_pkg.sv]
/*
  Shared constants and types for the moded asynchronous serial block.
  Assumes a single pclk domain and an APB register bus with 32-bit data.
*/
package asr_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam logic [7:0] OSC_DEF_MHZ = 8'h04;
  localparam int US_PER_MS = 1000;
  localparam logic [13:0] BAUD_BIAS_US = 14'h0014;
  localparam int BAUD_W = 13;
  localparam int MB_PARITY = 13;
  localparam int MB_INV = 14;
  localparam logic [11:0] TX_US_2400 = 12'h1A1;
  localparam logic [11:0] TX_US_1200 = 12'h341;
  localparam logic [11:0] TX_US_9600 = 12'h068;
  localparam logic [11:0] TX_US_300 = 12'hD05;
  localparam logic [3:0] TX_LAST_BIT = 4'h9;
  localparam logic [2:0] RX_LAST_BIT = 3'h7;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_RXMODE = 8'h00;
  localparam logic [7:0] A_RXCTRL = 8'h04;
  localparam logic [7:0] A_RXTMO = 8'h08;
  localparam logic [7:0] A_QUAL = 8'h0C;
  localparam logic [7:0] A_RXSTAT = 8'h10;
  localparam logic [7:0] A_RXVAL = 8'h14;
  localparam logic [7:0] A_TXCTRL = 8'h20;
  localparam logic [7:0] A_TXDATA = 8'h24;
  localparam logic [7:0] A_OSC = 8'h28;
  localparam logic [3:0] A_STR_HI = 4'h3;
  localparam logic [15:0] RXMODE_RST = 16'h0054;
  localparam logic [7:0] ASC_0 = 8'h30;
  localparam logic [7:0] ASC_1 = 8'h31;
  localparam logic [7:0] ASC_9 = 8'h39;
  localparam logic [7:0] ASC_UA = 8'h41;
  localparam logic [7:0] ASC_UF = 8'h46;
  localparam logic [7:0] ASC_LA = 8'h61;
  localparam logic [7:0] ASC_LF = 8'h66;
  localparam logic [7:0] HEX_U_OFS = 8'h37;
  localparam logic [7:0] HEX_L_OFS = 8'h57;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IT_RAW = 3'h0, IT_SKIP = 3'h1, IT_STR = 3'h2,
    IT_BIN = 3'h3, IT_DEC = 3'h4, IT_HEX = 3'h5
  } asr_item_e;
  typedef struct packed {
    logic [2:0] qlen;
    logic perr_en;
    logic flow_en;
    logic term_en;
    logic [7:0] term;
    logic [3:0] cnt;
    logic [2:0] kind;
    logic start;
  } asr_rxctrl_s;
  typedef struct packed {
    logic [15:0] pace_us;
    logic dec_fmt;
    logic [3:0] mode;
  } asr_txctrl_s;
endpackage

// [asr_far.sv]
/*
  Far-side serial device model: frames bytes onto the receive line, decodes the transmit line.
  Assumes it shares pclk with the bench and bit times are given in pclk cycles.
*/
`timescale 1ns/1ps
module asr_far (
  input wire logic pclk,
  input wire logic rx_inv,
  input wire logic tx_inv,
  input wire logic tx_pin_o,
  input wire logic tx_pin_oe_n,
  input wire logic [15:0] tx_bt,
  output logic rx_line,
  output logic got,
  output logic [7:0] got_byte
);
  // ----------------------------------------------------------------
  // Line model
  // ----------------------------------------------------------------
  logic raw = 1'b1;
  logic line;
  // A released pin floats to its idle level, as a pull resistor would.
  assign line = (tx_pin_oe_n ? ~tx_inv : tx_pin_o) ^ tx_inv;
  assign rx_line = raw ^ rx_inv;
  // Start, eight data bits LSB first, one stop bit at mark.
  task automatic send(input logic [7:0] b, input int bt);
    for (int i = 0; i < 10; i++) begin
      raw <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
      repeat (bt) @(posedge pclk);
    end
  endtask
  // Start is rechecked at half a bit, so a polarity switch glitch is not taken as a frame.
  initial got = 1'b0;
  always begin
    @(posedge pclk);
    got <= 1'b0;
    if (line === 1'b0) begin
      repeat (tx_bt / 2) @(posedge pclk);
      if (line === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (tx_bt) @(posedge pclk);
          got_byte[i] <= line;
        end
        repeat (tx_bt) @(posedge pclk);
        got <= 1'b1;
      end
    end
  end
endmodule

// [async_serial_rx_tx_mode_word_tb.sv]
/*
  Self-checking bench: APB master, expectation queues and the far-side serial model.
  Assumes asr_top runs with a timebase of 4 pclk cycles per microsecond.
*/
`timescale 1ns/1ps
module async_serial_rx_tx_mode_word_tb;
  import asr_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic pready, pslverr, rx_line, flow_o, flow_oe_n, tx_o, tx_oe_n, got;
  logic rx_inv = 1'b0, tx_inv = 1'b0;
  logic [7:0] got_byte, b;
  logic [7:0] msg [8] = '{8'h41, 8'h43, 8'h41, 8'h42, 8'h78, 8'h34, 8'h32, 8'h2C};
  logic [7:0] dig [3] = '{8'h31, 8'h32, 8'h33};
  logic [33:0] e;
  logic [33:0] expq[$];
  logic [7:0] txq[$];
  int num_errors = 0, comparisons = 0, cyc = 0, seed = 96, t0;
  asr_top #(.CYC_PER_US(4)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .serial_data_pin_i(rx_line),
    .flow_control_pin_o(flow_o), .flow_control_pin_oe_n(flow_oe_n), .tx_pin_o(tx_o),
    .tx_pin_oe_n(tx_oe_n));
  asr_far far_u (.pclk(pclk), .rx_inv(rx_inv), .tx_inv(tx_inv), .tx_pin_o(tx_o),
    .tx_pin_oe_n(tx_oe_n), .tx_bt(16'h01A0), .rx_line(rx_line), .got(got),
    .got_byte(got_byte));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [32:0] s, input logic [32:0] x);
    comparisons++;
    if (s !== x) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", n, x, s);
    end
  endtask
  // The request is held until pready is sampled high; the bus idles a cycle after.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] x);
    expq.push_back({1'b1, x});
    apb(1'b0, a, 32'h0);
  endtask
  // Polls bit 0 (busy) of a status word; these reads carry no expectation.
  task automatic poll(input logic [7:0] a);
    d = 32'h1;
    while (d[0]) begin
      expq.push_back(34'h0);
      apb(1'b0, a, 32'h0);
    end
  endtask
  task automatic complete_run();
    if (num_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, result watcher and hang guard
  // ----------------------------------------------------------------
  initial forever #10 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = expq.pop_front();
      if (e[33]) chk("read", {pslverr, prdata}, e[32:0]);
    end
    if (got) chk("tx byte", 33'(got_byte), 33'(txq.pop_front()));
    if (cyc == 100000) begin
      num_errors++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_RXMODE, 33'h000000054);
    rd(A_OSC, 33'h000000004);
    rd(8'hFC, 33'h100000000);
    // Plain 9600 true, then 19200 inverted with the unused top bit set.
    for (int i = 0; i < 2; i++) begin
      rx_inv <= i[0];
      apb(1'b1, A_RXMODE, i ? 32'h0000C020 : 32'h00000054);
      apb(1'b1, A_RXCTRL, 32'h00020001);
      repeat (4) @(posedge pclk);
      chk("flow oe", 33'(flow_oe_n), 33'h0);
      chk("flow level", 33'(flow_o), 33'(i == 0));
      b = 8'($random(seed));
      far_u.send(b, i ? 208 : 416);
      poll(A_RXSTAT);
      rd(A_RXSTAT, {17'h0, b, 8'h02});
      rd(A_RXVAL, 33'(b));
    end
    // A 7E1 character with wrong parity must take the parity exit.
    rx_inv <= 1'b0;
    apb(1'b1, A_RXMODE, 32'h00002020);
    apb(1'b1, A_RXCTRL, 32'h00040001);
    b = 8'($random(seed));
    b[7] = ~^b[6:0];
    far_u.send(b, 208);
    poll(A_RXSTAT);
    chk("parity exit", 33'(d[2]), 33'h1);
    // Qualifier restart, then a decimal number with leading and ending non-digits.
    apb(1'b1, A_RXMODE, 32'h00000020);
    apb(1'b1, A_QUAL, 32'h00004241);
    apb(1'b1, A_RXCTRL, 32'h00100009);
    foreach (msg[i]) far_u.send(msg[i], 208);
    poll(A_RXSTAT);
    rd(A_RXVAL, 33'h00000002A);
    // Skip two characters, then a two-digit hex number with a lower-case letter.
    apb(1'b1, A_RXCTRL, 32'h00000023);
    repeat (2) far_u.send(8'($random(seed)), 208);
    poll(A_RXSTAT);
    chk("skip done", 33'(d[1]), 33'h1);
    apb(1'b1, A_RXCTRL, 32'h0000002B);
    far_u.send(8'h37, 208);
    far_u.send(8'h66, 208);
    poll(A_RXSTAT);
    rd(A_RXVAL, 33'h00000007F);
    // One millisecond with a silent line must end in the timeout exit.
    apb(1'b1, A_RXTMO, 32'h00000001);
    apb(1'b1, A_RXCTRL, 32'h00000001);
    t0 = cyc;
    poll(A_RXSTAT);
    chk("timeout exit", 33'(d[3]), 33'h1);
    chk("timeout time", 33'(cyc - t0 >= 3990 && cyc - t0 < 4040), 33'h1);
    // The four 9600 codes: driven and open, true and inverted.
    for (int i = 2; i < 16; i += 4) begin
      tx_inv <= i[2];
      apb(1'b1, A_TXCTRL, 32'(i));
      b = 8'($random(seed));
      txq.push_back(b);
      apb(1'b1, A_TXDATA, 32'(b));
      poll(A_TXDATA);
      chk("tx oe", 33'(tx_oe_n), 33'(i > 7));
    end
    // Decimal format sends the digits of 123.
    tx_inv <= 1'b0;
    apb(1'b1, A_TXCTRL, 32'h00000012);
    foreach (dig[i]) txq.push_back(dig[i]);
    apb(1'b1, A_TXDATA, 32'h0000007B);
    poll(A_TXDATA);
    while (txq.size() > 0) @(posedge pclk);
    complete_run();
  end
endmodule
